// ---- rtl/sdl_pkg.sv ----
// Shared constants, carriers and code tables for the 8b/10b serial link.
// Assumes one clock domain; users reach every name as sdl_pkg::name.
package sdl_pkg;

	// Symbol geometry and counters.
	localparam int         SYM_BITS  = 10;
	localparam int         BYTE_BITS = 8;
	localparam logic [3:0] SYM_LAST  = 4'h9;
	localparam logic [3:0] CNT_RESET = 4'h0;

	// Reset values of state and outputs.
	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic [9:0] RST_SYM   = 10'h000;
	localparam logic       RST_BIT   = 1'b0;
	localparam logic       RD_RESET  = 1'b0; // 0 is negative running disparity.

	// Field positions of a byte and of the packed abcdei_fghj code.
	localparam int X_LSB = 0;
	localparam int X_MSB = 4;
	localparam int Y_LSB = 5;
	localparam int Y_MSB = 7;
	localparam int C6_LSB = 4;
	localparam int C6_MSB = 9;
	localparam int C4_LSB = 0;
	localparam int C4_MSB = 3;

	// Special codes of D.7, D.x.3 and the alternate D.x.7 form.
	localparam logic [4:0] X_D7    = 5'h07;
	localparam logic [2:0] Y_D3    = 3'h3;
	localparam logic [2:0] Y_D7    = 3'h7;
	localparam logic [3:0] A7_NEG  = 4'h7;
	localparam logic [3:0] A7_POS  = 4'h8;

	// Encoder result: symbol (bit 0 goes on the line first) and running disparity after it.
	typedef struct packed {
		logic [9:0] sym;
		logic       rd;
	} sdl_enc_t;

	// Decoder result: recovered byte and a flag for a word outside the code.
	typedef struct packed {
		logic [7:0] data;
		logic       err;
	} sdl_dec_t;

	// Six-bit sub-block, form used under negative disparity, a in the top bit.
	function automatic logic [5:0] code6_neg(input logic [4:0] x);
		logic [5:0] c;
		c = 6'h00;
		unique case (x)
			5'h00: c = 6'h27;
			5'h01: c = 6'h1d;
			5'h02: c = 6'h2d;
			5'h03: c = 6'h31;
			5'h04: c = 6'h35;
			5'h05: c = 6'h29;
			5'h06: c = 6'h19;
			5'h07: c = 6'h38;
			5'h08: c = 6'h39;
			5'h09: c = 6'h25;
			5'h0a: c = 6'h15;
			5'h0b: c = 6'h34;
			5'h0c: c = 6'h0d;
			5'h0d: c = 6'h2c;
			5'h0e: c = 6'h1c;
			5'h0f: c = 6'h17;
			5'h10: c = 6'h1b;
			5'h11: c = 6'h23;
			5'h12: c = 6'h13;
			5'h13: c = 6'h32;
			5'h14: c = 6'h0b;
			5'h15: c = 6'h2a;
			5'h16: c = 6'h1a;
			5'h17: c = 6'h3a;
			5'h18: c = 6'h33;
			5'h19: c = 6'h26;
			5'h1a: c = 6'h16;
			5'h1b: c = 6'h36;
			5'h1c: c = 6'h0e;
			5'h1d: c = 6'h2e;
			5'h1e: c = 6'h1e;
			5'h1f: c = 6'h2b;
		endcase
		return c;
	endfunction

	// Four-bit sub-block, primary form under negative disparity, f in the top bit.
	function automatic logic [3:0] code4_neg(input logic [2:0] y);
		logic [3:0] c;
		c = 4'h0;
		unique case (y)
			3'h0: c = 4'hb;
			3'h1: c = 4'h9;
			3'h2: c = 4'h5;
			3'h3: c = 4'hc;
			3'h4: c = 4'hd;
			3'h5: c = 4'ha;
			3'h6: c = 4'h6;
			3'h7: c = 4'he;
		endcase
		return c;
	endfunction

	// A six-bit code whose complement is also legal for the same value.
	function automatic logic inv6_ok(input logic [4:0] x);
		return ($countones(code6_neg(x)) != 3) || (x == X_D7);
	endfunction

	// A four-bit code whose complement is also legal for the same value.
	function automatic logic inv4_ok(input logic [2:0] y);
		return ($countones(code4_neg(y)) != 2) || (y == Y_D3);
	endfunction

endpackage

// ---- rtl/sdl_encoder.sv ----
// Combinational 8b/10b encoder for one data byte.
// Assumes the caller holds running disparity and feeds it back in.
`timescale 1ns/1ps

module sdl_encoder
(
	input  wire logic [7:0]       byte_i,
	input  wire logic             rd_i,
	output sdl_pkg::sdl_enc_t     enc_o
);

	logic [4:0] x;
	logic [2:0] y;
	logic [5:0] c6n;
	logic [5:0] c6;
	logic [3:0] c4n;
	logic [3:0] c4;
	logic       flip6;
	logic       flip4;
	logic       rd_mid;
	logic       alt7;
	logic [9:0] packed_code;

	// Six-bit block: complement under positive disparity where the code allows it.
	assign x      = byte_i[sdl_pkg::X_MSB:sdl_pkg::X_LSB];
	assign y      = byte_i[sdl_pkg::Y_MSB:sdl_pkg::Y_LSB];
	assign c6n    = sdl_pkg::code6_neg(x);
	assign flip6  = ($countones(c6n) != 3);
	assign c6     = (rd_i && sdl_pkg::inv6_ok(x)) ? ~c6n : c6n;
	assign rd_mid = rd_i ^ flip6;

	// The alternate x.7 form avoids a run of five equal bits across the blocks.
	assign alt7  = (y == sdl_pkg::Y_D7) &&
		((!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
		(rd_mid && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
	assign c4n   = alt7 ? sdl_pkg::A7_NEG : sdl_pkg::code4_neg(y);
	assign flip4 = ($countones(c4n) != 2);
	assign c4    = (rd_mid && (flip4 || y == sdl_pkg::Y_D3)) ? ~c4n : c4n;

	// Bit a of the code lands in symbol bit 0, so it is sent first.
	assign packed_code = {c6, c4};
	generate
		for (genvar k = 0; k < sdl_pkg::SYM_BITS; k++)
		begin : g_order
			assign enc_o.sym[k] = packed_code[sdl_pkg::SYM_BITS - 1 - k];
		end
	endgenerate
	assign enc_o.rd = rd_mid ^ flip4;

endmodule

// ---- rtl/sdl_link.sv ----
// Top of the 8b/10b serializer and deserializer.
// Assumes all inputs synchronous to ref_clk_i and a peer sending bit a first.
// Assumes the host watches the boundary flag to time its word captures.
`timescale 1ns/1ps

module sdl_link
(
	input  wire logic       ref_clk_i,
	input  wire logic       srst_i,
	input  wire logic       ce_i,
	input  wire logic [7:0] tx_parallel_byte_i,
	input  wire logic       word_latch_en_i,
	input  wire logic       ser_en_i,
	input  wire logic       par_en_i,
	input  wire logic       ser_in_i,
	output logic            ser_out_o,
	output logic [7:0]      rx_parallel_byte_o,
	output logic            rx_code_err_o,
	output logic            rx_boundary_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Transmit path.
	// The symbol counter advances only on enabled serial edges, so a pause on ser_en_i or ce_i
	// stretches the symbol on the line rather than cutting it short.
	// A byte latched part way through a symbol waits for the next symbol start, so the host
	// must latch before the enabled edge on which the counter sits at zero to have it sent next.

	// Transmit state and the next values that feed it.
	logic [7:0]         tx_hold;
	logic [9:0]         tx_shift;
	logic [3:0]         tx_cnt;
	logic               tx_rd;
	sdl_pkg::sdl_enc_t  tx_enc;
	logic               tx_step;
	logic               tx_load;
	logic [3:0]         next_tx_cnt;
	logic [9:0]         next_tx_shift;
	logic               next_ser_out;
	logic               next_tx_rd;

	// Host byte capture; a byte held across several symbols is simply resent.
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			tx_hold <= sdl_pkg::RST_BYTE;
		else if (ce_i && word_latch_en_i)
			tx_hold <= tx_parallel_byte_i;
	end

	// The encoder is purely combinational and sees the disparity left by the symbol just sent,
	// which is why tx_rd only moves on a load edge.
	sdl_encoder u_encoder
	(
		.byte_i (tx_hold),
		.rd_i   (tx_rd),
		.enc_o  (tx_enc)
	);

	// At a symbol boundary the fresh code is loaded and its first bit goes out at once.
	// The shift register fills with zeros from the top; only the counter says where a symbol ends.
	assign tx_step       = ce_i && ser_en_i;
	assign tx_load       = (tx_cnt == sdl_pkg::CNT_RESET);
	assign next_tx_cnt   = (tx_cnt == sdl_pkg::SYM_LAST) ? sdl_pkg::CNT_RESET : tx_cnt + 4'h1;
	assign next_tx_shift = tx_load ? {1'b0, tx_enc.sym[9:1]} : {1'b0, tx_shift[9:1]};
	assign next_ser_out  = tx_load ? tx_enc.sym[0] : tx_shift[0];
	assign next_tx_rd    = tx_load ? tx_enc.rd : tx_rd;

	// Serializer; disparity advances once per symbol, only when it is really sent.
	// The serial output stands between enabled edges, so a paused link holds its last bit.
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			tx_shift  <= sdl_pkg::RST_SYM;
			tx_cnt    <= sdl_pkg::CNT_RESET;
			tx_rd     <= sdl_pkg::RD_RESET;
			ser_out_o <= sdl_pkg::RST_BIT;
		end
		else if (tx_step)
		begin
			tx_shift  <= next_tx_shift;
			tx_cnt    <= next_tx_cnt;
			tx_rd     <= next_tx_rd;
			ser_out_o <= next_ser_out;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receive path.
	// There is no comma search: alignment rests wholly on a bit count kept from reset, which saves
	// a comparator bank but means the far end must begin its first symbol on the first enabled shift.
	// A peer that slips one bit leaves every later word misaligned until the next reset.

	// Receive state and the next values that feed it.
	logic [9:0]         rx_shift;
	logic [3:0]         rx_cnt;
	logic [9:0]         rx_hold;
	logic               rx_step;
	logic [3:0]         next_rx_cnt;
	logic [9:0]         next_rx_shift;
	logic               next_rx_boundary;

	// New bits enter at the top, so after ten shifts the first bit sits in bit 0.
	assign rx_step          = ce_i && par_en_i;
	assign next_rx_shift    = {ser_in_i, rx_shift[9:1]};
	assign next_rx_cnt      = (rx_cnt == sdl_pkg::SYM_LAST) ? sdl_pkg::CNT_RESET : rx_cnt + 4'h1;
	assign next_rx_boundary = rx_step && (rx_cnt == sdl_pkg::SYM_LAST);

	// Deserializer and boundary counter; the counter is never resynchronised to the data.
	// The boundary flag is refreshed on every enabled edge, so it stands for one enabled cycle only.
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			rx_shift      <= sdl_pkg::RST_SYM;
			rx_cnt        <= sdl_pkg::CNT_RESET;
			rx_boundary_o <= sdl_pkg::RST_BIT;
		end
		else if (ce_i)
		begin
			rx_boundary_o <= next_rx_boundary;
			if (par_en_i)
			begin
				rx_shift <= next_rx_shift;
				rx_cnt   <= next_rx_cnt;
			end
		end
	end

	// Word capture; the host times it on the boundary flag to get aligned symbols.
	// The same latch enable also loads the transmit byte, so both directions are planned together.
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			rx_hold <= sdl_pkg::RST_SYM;
		else if (ce_i && word_latch_en_i)
			rx_hold <= rx_shift;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decoder.
	// The decoder works from the hold register alone, so the parallel output moves one clock
	// after a capture and then stands until the next one.
	// Only data codes are decoded; a control code is flagged or read as the byte sharing its sub-blocks.

	// Decoder nets; dec carries the byte and the error flag together.
	logic [9:0]         rx_code;
	logic [5:0]         rx_c6;
	logic [3:0]         rx_c4;
	logic [31:0]        hit6;
	logic [7:0]         hit4;
	logic               hit_a7;
	logic [4:0]         dec_x;
	logic [2:0]         dec_y;
	sdl_pkg::sdl_dec_t  dec;

	// Undo the line order so bit a is again the top bit of the packed code.
	// The hold register keeps bit a in bit 0, the same order in which the encoder lays it out.
	generate
		for (genvar k = 0; k < sdl_pkg::SYM_BITS; k++)
		begin : g_unorder
			assign rx_code[sdl_pkg::SYM_BITS - 1 - k] = rx_hold[k];
		end
	endgenerate
	assign rx_c6 = rx_code[sdl_pkg::C6_MSB:sdl_pkg::C6_LSB];
	assign rx_c4 = rx_code[sdl_pkg::C4_MSB:sdl_pkg::C4_LSB];

	// One comparator per table entry; a complement only counts where it is a legal form,
	// since some balanced codes complement into a different value's code.
	generate
		for (genvar k = 0; k < 32; k++)
		begin : g_hit6
			assign hit6[k] = (rx_c6 == sdl_pkg::code6_neg(5'(k))) ||
				(sdl_pkg::inv6_ok(5'(k)) && rx_c6 == ~sdl_pkg::code6_neg(5'(k)));
		end
		for (genvar k = 0; k < 8; k++)
		begin : g_hit4
			assign hit4[k] = (rx_c4 == sdl_pkg::code4_neg(3'(k))) ||
				(sdl_pkg::inv4_ok(3'(k)) && rx_c4 == ~sdl_pkg::code4_neg(3'(k)));
		end
	endgenerate
	// Either polarity of the alternate form stands for the value 7 of the upper field.
	assign hit_a7 = (rx_c4 == sdl_pkg::A7_NEG) || (rx_c4 == sdl_pkg::A7_POS);

	// Codes are unique, so at most one hit is set and an OR of indices recovers the value.
	// The alternate x.7 form has its own match, since it is not the complement of the primary code.
	always_comb
	begin
		dec_x = 5'h00;
		dec_y = hit_a7 ? sdl_pkg::Y_D7 : 3'h0;
		for (int k = 0; k < 32; k++)
			dec_x = dec_x | (hit6[k] ? 5'(k) : 5'h00);
		for (int k = 0; k < 8; k++)
			dec_y = dec_y | (hit4[k] ? 3'(k) : 3'h0);
	end

	// Disparity is not checked; only words outside the code raise the error flag.
	// A legal code that arrives at the wrong disparity therefore still decodes as data.
	assign dec.data = {dec_y, dec_x};
	assign dec.err  = !(|hit6) || !(hit_a7 || |hit4);

	// Output registers so the parallel pins never see decoder glitches.
	// Reset takes priority over ce_i, so a frozen link can still be brought back to idle.
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			rx_parallel_byte_o <= sdl_pkg::RST_BYTE;
			rx_code_err_o      <= sdl_pkg::RST_BIT;
		end
		else if (ce_i)
		begin
			rx_parallel_byte_o <= dec.data;
			rx_code_err_o      <= dec.err;
		end
	end

endmodule

// ---- tb/sdl_peer.sv ----
// Far-side peer: puts one symbol on the link's serial input, code bit a first.
// Assumes it is stepped on exactly the edges on which the link shifts in.
`timescale 1ns/1ps
module sdl_peer
(
	input  wire logic       clk_i,
	input  wire logic       load_i,
	input  wire logic [9:0] sym_i,
	input  wire logic       step_i,
	output logic            line_o
);
	logic [9:0] sym = 10'h000;
	logic [3:0] left = 4'h0;
	logic       junk = 1'b0;
	////////////////////////////////////////
	// Between symbols the line toggles, so a stale bit never passes for data.
	assign line_o = (left != 4'h0) ? sym[0] : junk;
	// One bit per stepped edge, least significant first.
	always @(posedge clk_i)
	begin
		junk <= ~junk;
		if (load_i)
		begin
			sym  <= sym_i;
			left <= 4'ha;
		end
		else if (step_i && left != 4'h0)
		begin
			sym  <= sym >> 1;
			left <= left - 4'h1;
		end
	end
endmodule

// ---- tb/sdl_link_checker.sv ----
// Port assertions for the serial link top.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
module sdl_link_checker
(
	input wire logic       ref_clk_i,
	input wire logic       srst_i,
	input wire logic       ce_i,
	input wire logic [7:0] tx_parallel_byte_i,
	input wire logic       word_latch_en_i,
	input wire logic       ser_en_i,
	input wire logic       par_en_i,
	input wire logic       ser_in_i,
	input wire logic       ser_out_o,
	input wire logic [7:0] rx_parallel_byte_o,
	input wire logic       rx_code_err_o,
	input wire logic       rx_boundary_o
);
	logic [3:0] shifts;
	////////////////////////////////////////
	// Shifts since reset, wrapping after a whole symbol.
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			shifts <= 4'h0;
		else if (ce_i && par_en_i)
			shifts <= (shifts == 4'h9) ? 4'h0 : shifts + 4'h1;
	end
	////////////////////////////////////////
	// The first two look back across reset, since the disable hides the reset edge.
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (srst_i);
	rst_clear_a: assert property ($past(srst_i) |->
		{ser_out_o, rx_boundary_o, rx_code_err_o, rx_parallel_byte_o} == 11'h000) else $error("not cleared");
	err_reset_a: assert property ($past(srst_i) && ce_i |=> rx_code_err_o) else $error("zero word passed");
	rx_hold_a: assert property (ce_i && !word_latch_en_i && $past(ce_i && !word_latch_en_i) && !$past(srst_i)
		|=> $stable({rx_parallel_byte_o, rx_code_err_o})) else $error("output moved");
	tx_hold_a: assert property (!(ce_i && ser_en_i) |=> $stable(ser_out_o)) else $error("serial out moved");
	ce_freeze_a: assert property (!ce_i |=> $stable({rx_parallel_byte_o, rx_boundary_o})) else $error("moved");
	bnd_count_a: assert property (ce_i && par_en_i |=> rx_boundary_o == ($past(shifts) == 4'h9))
		else $error("bad boundary");
	bnd_quiet_a: assert property (ce_i && !par_en_i |=> !rx_boundary_o) else $error("boundary no shift");
	bnd_cause_a: assert property ($rose(rx_boundary_o) |-> $past(ce_i && par_en_i)) else $error("boundary idle");
	// Main events seen at least once.
	cover property (rx_boundary_o);
	cover property (rx_code_err_o);
	cover property (!ce_i && ser_en_i);
endmodule
bind sdl_link sdl_link_checker u_chk (.ref_clk_i, .srst_i, .ce_i, .tx_parallel_byte_i, .word_latch_en_i,
	.ser_en_i, .par_en_i, .ser_in_i, .ser_out_o, .rx_parallel_byte_o, .rx_code_err_o, .rx_boundary_o);

// ---- tb/sdl_link_tb.sv ----
// Bench for the serial link; inputs change at falling edges, a peer feeds the serial input.
// Assumes the port checker is bound from its own file.
`timescale 1ns/1ps
module sdl_link_tb;
	logic       ref_clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, word_latch_en_i = 1'b0, ser_en_i = 1'b0;
	logic       par_en_i = 1'b0, load = 1'b0, ser_in_i, ser_out_o, rx_code_err_o, rx_boundary_o;
	logic [7:0] tx_parallel_byte_i = 8'h00, rx_parallel_byte_o;
	logic [9:0] psym = 10'h000;
	int         n_errors = 0, num_checks = 0;
	////////////////////////////////////////
	// Clock at 40 MHz; the peer steps on the link's shift edges.
	always #12.5 ref_clk_i = ~ref_clk_i;
	sdl_link dut (.ref_clk_i, .srst_i, .ce_i, .tx_parallel_byte_i, .word_latch_en_i, .ser_en_i, .par_en_i,
		.ser_in_i, .ser_out_o, .rx_parallel_byte_o, .rx_code_err_o, .rx_boundary_o);
	sdl_peer peer (.clk_i(ref_clk_i), .load_i(load), .sym_i(psym), .step_i(ce_i && par_en_i), .line_o(ser_in_i));
	////////////////////////////////////////
	// Every comparison is counted; a mismatch is reported at once.
	task automatic chk(input logic [10:0] got, input logic [10:0] want);
		num_checks++;
		if (got !== want)
		begin
			n_errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic tally_and_finish();
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// All outputs idle right after a reset edge.
	task automatic t_reset();
		chk({ser_out_o, rx_boundary_o, rx_code_err_o, rx_parallel_byte_o}, 11'h000);
	endtask
	// A byte, a byte swapped in mid-symbol with a pause, then that byte resent at the other disparity.
	task automatic t_tx();
		logic [29:0] exp;
		int          b;
		exp = {10'h246, 10'h279, 10'h155};
		tx_parallel_byte_i = 8'hb5;
		word_latch_en_i = 1'b1;
		@(negedge ref_clk_i);
		tx_parallel_byte_i = 8'h20;
		for (int k = 0; k < 32; k++)
		begin
			ser_en_i = (k != 4);
			ce_i = (k != 5);
			word_latch_en_i = (k == 4);
			@(negedge ref_clk_i);
			b = (k < 4) ? k : ((k < 6) ? 3 : k - 2);
			chk(11'(ser_out_o), 11'(exp[b]));
		end
		ser_en_i = 1'b0;
	endtask
	// The peer sends one symbol; the word is captured right after the boundary.
	task automatic t_rx(input logic [9:0] sym, input logic [7:0] dat, input logic err);
		psym = sym;
		load = 1'b1;
		@(negedge ref_clk_i);
		load = 1'b0;
		par_en_i = 1'b1;
		for (int k = 0; k < 10; k++)
		begin
			@(negedge ref_clk_i);
			chk(11'(rx_boundary_o), 11'(k == 9));
		end
		par_en_i = 1'b0;
		word_latch_en_i = 1'b1;
		@(negedge ref_clk_i);
		word_latch_en_i = 1'b0;
		@(negedge ref_clk_i);
		chk(11'(rx_code_err_o), 11'(err));
		chk(11'(err ? 8'h00 : rx_parallel_byte_o), 11'(dat));
	endtask
	// Reset in mid-symbol clears the outputs and restarts the bit count.
	task automatic t_rst_mid();
		par_en_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		par_en_i = 1'b0;
		srst_i = 1'b1;
		@(negedge ref_clk_i);
		t_reset();
		srst_i = 1'b0;
		t_rx(10'h155, 8'hb5, 1'b0);
	endtask
	// Main sequence.
	initial
	begin
		repeat (10) @(negedge ref_clk_i);
		t_reset();
		srst_i = 1'b0;
		t_tx();
		t_rx(10'h279, 8'h20, 1'b0);
		t_rx(10'h246, 8'h20, 1'b0);
		t_rx(10'h155, 8'hb5, 1'b0);
		t_rx(10'h000, 8'h00, 1'b1);
		t_rst_mid();
		tally_and_finish();
	end
	// A hang ends the run as a mismatch.
	initial
	begin
		repeat (2000) @(posedge ref_clk_i);
		n_errors++;
		tally_and_finish();
	end
endmodule
